// file: hw/mbiram_core.sv
// Serial self-test instruction register, read compare and per-CPU fail logs.
// Assumes the tester keeps its shift, run and log-shift controls synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module mbiram_core
    import mbiram_pkg::*;
#(
    parameter int cpu_count_param = 4,
    parameter logic [NCPU-1:0] cpu_slot_present = 4'hF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_instr_in,
    input wire logic instr_shift_en,
    input wire logic log_shift_en,
    input wire logic test_run_en,
    input wire logic read_check,
    input wire logic [ADDR_W-1:0] test_address,
    input wire logic [DATA_W-1:0] test_write_data,
    input wire logic [NCPU*DATA_W-1:0] test_read_data,
    output logic [NSEL-1:0] ram_select,
    output logic [5:0] pattern_sel,
    output logic [5:0] ctrl_options,
    output logic [2:0] write_latency,
    output logic [2:0] read_latency,
    output logic [3:0] max_x_addr,
    output logic [3:0] max_y_addr,
    output logic [3:0] data_seed,
    output logic [5:0] column_width,
    output logic [3:0] data_addr_bits,
    output logic [3:0] tag_addr_bits,
    output logic [NCPU-1:0] serial_result,
    output logic fail_detect,
    output logic ctrl_stall,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [INSTR_W-1:0] instr;
        logic [NCPU-1:0][LOG_W-1:0] log;
        logic [NCPU-1:0] fail_seen;
        logic [NSEL-1:0] ram_sel;
        logic [3:0] seed;
        logic [5:0] colw;
        logic [3:0] daddr;
        logic [3:0] taddr;
        logic [NCPU-1:0] ser;
        logic fail;
        logic stall;
        logic cmp_en;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mbiram_state_s;

    mbiram_state_s s_q;
    mbiram_state_s s_d;

    // Slots beyond the configured count are treated as absent
    logic [NCPU-1:0] cpu_active;
    genvar gc;
    generate
        for (gc = 0; gc < NCPU; gc++) begin : g_act
            assign cpu_active[gc] = cpu_slot_present[gc] && (gc < cpu_count_param);
        end
    endgenerate

    logic [DATA_W-1:0] cmp_mask;
    logic [NCPU-1:0] cpu_cmp_en;
    logic [NCPU-1:0][DATA_W-1:0] miscmp;
    logic [3:0] seed_eff;
    logic do_cmp;
    logic clr_fail;
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        s_d = s_q;
        clr_fail = 1'b0;
        rd_word = 32'h0;
        rd_hit = 1'b1;
        // ======================================================
        // Instruction register: a right shift puts the first bit at 0
        if (instr_shift_en) begin
            s_d.instr = {serial_instr_in, s_q.instr[INSTR_W-1:1]};
        end
        // Go/no-go runs always use the fixed seed
        seed_eff = (s_q.instr[PAT_LSB+:6] == PAT_GONOGO) ? GONOGO_SEED
                                                         : s_q.instr[SEED_LSB+:4];
        // Decoded values are refreshed only outside loading, so they never ripple
        if (!instr_shift_en) begin
            s_d.seed = seed_eff;
            s_d.colw = mbiram_colw(s_q.instr[COLW_LSB+:2]);
            s_d.daddr = mbiram_daddr(s_q.instr[CSIZE_LSB+:2]);
            s_d.taddr = mbiram_daddr(s_q.instr[CSIZE_LSB+:2]) - 4'h2;
        end
        s_d.ram_sel = (test_run_en && !instr_shift_en) ? s_q.instr[ARR_LSB+:NSEL]
                                                       : {NSEL{1'b0}};
        // ======================================================
        // Read compare on the arrays that are enabled
        cmp_mask = mbiram_mask(s_q.ram_sel, s_q.instr[CSIZE_LSB+:2]);
        cpu_cmp_en = s_q.instr[CPUEN_LSB+:NCPU] & cpu_active;
        do_cmp = test_run_en && read_check && s_q.cmp_en && !s_q.stall;
        for (int c = 0; c < NCPU; c++) begin
            miscmp[c] = (test_read_data[c*DATA_W+:DATA_W] ^ test_write_data) & cmp_mask;
            // First failure per CPU is kept until software clears it
            if (do_cmp && cpu_cmp_en[c] && (|miscmp[c]) && !s_q.fail_seen[c]) begin
                s_d.log[c] = {test_address, miscmp[c], s_q.seed};
                s_d.fail_seen[c] = 1'b1;
            end
        end
        // ======================================================
        // Serial result lanes
        s_d.stall = log_shift_en;
        if (log_shift_en) begin
            for (int c = 0; c < NCPU; c++) begin
                s_d.ser[c] = s_q.log[c][0];
                s_d.log[c] = {1'b0, s_q.log[c][LOG_W-1:1]};
            end
        end else if (instr_shift_en) begin
            s_d.ser = {NCPU{s_q.instr[0]}};
        end else begin
            s_d.ser = {NCPU{1'b0}};
        end
        // ======================================================
        // AXI4-Lite write
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            unique case (s_q.aw_addr)
                OFS_CTRL: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cmp_en = s_q.w_data[0];
                        clr_fail = s_q.w_data[1];
                    end
                end
                OFS_STATUS, OFS_INSTR_LO, OFS_INSTR_HI, OFS_CFG: begin
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // A fail caught in the clearing cycle survives the clear
        if (clr_fail) begin
            for (int c = 0; c < NCPU; c++) begin
                if (!(do_cmp && cpu_cmp_en[c] && (|miscmp[c]) && !s_q.fail_seen[c])) begin
                    s_d.fail_seen[c] = 1'b0;
                end
            end
        end
        s_d.fail = |s_d.fail_seen;
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
        // ======================================================
        // AXI4-Lite read
        unique case (s_axi_araddr)
            OFS_CTRL: rd_word = {30'h0, 1'b0, s_q.cmp_en};
            OFS_STATUS: rd_word = {26'h0, s_q.stall, s_q.fail, s_q.fail_seen};
            OFS_INSTR_LO: rd_word = s_q.instr[31:0];
            OFS_INSTR_HI: rd_word = {8'h00, s_q.instr[INSTR_W-1:32]};
            OFS_CFG: rd_word = {16'h0, s_q.taddr, s_q.daddr, 2'h0, s_q.colw};
            default: rd_hit = 1'b0;
        endcase
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.cmp_en <= CMP_EN_RST;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign ram_select = s_q.ram_sel;
    assign pattern_sel = s_q.instr[PAT_LSB+:6];
    assign ctrl_options = s_q.instr[OPT_LSB+:6];
    assign write_latency = s_q.instr[WLAT_LSB+:3];
    assign read_latency = s_q.instr[RLAT_LSB+:3];
    assign max_x_addr = s_q.instr[MAXX_LSB+:4];
    assign max_y_addr = s_q.instr[MAXY_LSB+:4];
    assign data_seed = s_q.seed;
    assign column_width = s_q.colw;
    assign data_addr_bits = s_q.daddr;
    assign tag_addr_bits = s_q.taddr;
    assign serial_result = s_q.ser;
    assign fail_detect = s_q.fail;
    assign ctrl_stall = s_q.stall;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rvalid = s_q.rvalid;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_shift_bit;
        instr_shift_en ##1 1'b1;
    endsequence

    property p_shift_in;
        instr_shift_en |=> s_q.instr[55] == $past(serial_instr_in)
                           && s_q.instr[54:0] == $past(s_q.instr[55:1]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift order wrong");

    property p_hold;
        !instr_shift_en |=> $stable(s_q.instr);
    endproperty
    a_hold: assert property (p_hold) else $error("instruction moved");

    property p_ramsel;
        test_run_en && !instr_shift_en |=> ram_select == $past(s_q.instr[21:4]);
    endproperty
    a_ramsel: assert property (p_ramsel) else $error("ram select wrong");

    // The edge that leaves reset still resets the decode, so it is skipped
    property p_colw;
        aresetn && !instr_shift_en |=> column_width == (6'h04 << $past(s_q.instr[3:2]));
    endproperty
    a_colw: assert property (p_colw) else $error("column width wrong");

    property p_csize;
        !instr_shift_en ##1 !instr_shift_en |=> data_addr_bits ==
            ((s_q.instr[1:0] == 2'h3) ? 4'hB : (s_q.instr[1:0] == 2'h2) ? 4'hA : 4'h9);
    endproperty
    a_csize: assert property (p_csize) else $error("cache size decode wrong");

    property p_seed;
        !instr_shift_en && s_q.instr[55:50] == 6'h3F |=> data_seed == 4'h5;
    endproperty
    a_seed: assert property (p_seed) else $error("go/no-go seed not forced");

    property p_enable_only;
        !s_q.instr[33] && !log_shift_en |=> !$rose(s_q.fail_seen[0]);
    endproperty
    a_enable_only: assert property (p_enable_only) else $error("disabled CPU logged");

    property p_log_layout;
        do_cmp && cpu_cmp_en[0] && (|miscmp[0]) && !s_q.fail_seen[0] && !log_shift_en
        |=> s_q.log[0][78:68] == $past(test_address) && s_q.log[0][3:0] == $past(s_q.seed);
    endproperty
    a_log_layout: assert property (p_log_layout) else $error("fail log layout wrong");

    property p_stall;
        s_shift_bit or (log_shift_en ##1 1'b1) |-> ctrl_stall == $past(log_shift_en);
    endproperty
    a_stall: assert property (p_stall) else $error("stall does not follow log shift");

    property p_taddr;
        !instr_shift_en ##1 !instr_shift_en |=> tag_addr_bits ==
            ((s_q.instr[1:0] == 2'h3) ? 4'h9 : (s_q.instr[1:0] == 2'h2) ? 4'h8 : 4'h7);
    endproperty
    a_taddr: assert property (p_taddr) else $error("tag address width wrong");

    // At the largest cache size the two low tag bits are never compared
    property p_dtag_skip;
        do_cmp && s_q.ram_sel == 18'h00400 && s_q.instr[1:0] == 2'h3
        && (test_read_data[63:0] ^ test_write_data) == 64'h0000000000000003
        |=> !$rose(s_q.fail_seen[0]);
    endproperty
    a_dtag_skip: assert property (p_dtag_skip) else $error("tag bit compared");

    // Padding above each instruction tag carries no data
    property p_itag_pad;
        do_cmp && s_q.ram_sel == 18'h00008
        && (test_read_data[63:0] ^ test_write_data) == 64'h0000000000200000
        |=> !$rose(s_q.fail_seen[0]);
    endproperty
    a_itag_pad: assert property (p_itag_pad) else $error("tag padding compared");

    // The unused top bit of the branch target word never logs a fail
    property p_btac_pad;
        do_cmp && s_q.ram_sel == 18'h00004
        && (test_read_data[63:0] ^ test_write_data) == 64'h8000000000000000
        |=> !$rose(s_q.fail_seen[0]);
    endproperty
    a_btac_pad: assert property (p_btac_pad) else $error("top bit compared");

    // Each lane shows the oldest log bit one edge after the shift
    property p_log_out;
        log_shift_en |=> serial_result[1] == $past(s_q.log[1][0]);
    endproperty
    a_log_out: assert property (p_log_out) else $error("log bit order wrong");

endmodule // mbiram_core

`default_nettype wire

// file: hw/mbiram_pkg.sv
// Constants, types and decode helpers of the memory self-test instruction block.
// Assumes a single 20 MHz clock domain and a synchronous active-low reset.
package mbiram_pkg;

    // ==========================================================
    // Instruction register layout
    localparam int INSTR_W = 56;
    localparam int CTRL_BITS = 18;
    localparam int DISP_BITS = 38;
    localparam int PAT_LSB = 50;
    localparam int OPT_LSB = 44;
    localparam int WLAT_LSB = 41;
    localparam int RLAT_LSB = 38;
    localparam int CPUEN_LSB = 33;
    localparam int MAXX_LSB = 30;
    localparam int MAXY_LSB = 26;
    localparam int SEED_LSB = 22;
    localparam int ARR_LSB = 4;
    localparam int COLW_LSB = 2;
    localparam int CSIZE_LSB = 0;
    localparam logic [5:0] PAT_GONOGO = 6'h3F;
    localparam logic [3:0] GONOGO_SEED = 4'h5;

    // ==========================================================
    // Data paths and fail log
    localparam int NCPU = 4;
    localparam int DATA_W = 64;
    localparam int ADDR_W = 11;
    localparam int NSEL = 18;
    localparam int LOG_W = 79;

    // ==========================================================
    // Register map (byte offsets) and reset values
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INSTR_LO = 8'h08;
    localparam logic [7:0] OFS_INSTR_HI = 8'h0C;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic CMP_EN_RST = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NSEL-1:0] ram_sel;
        logic [DATA_W-1:0] wdata;
        logic [NCPU*DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
    } mbiram_ram_s;

    // Column width code 00..11 gives 4, 8, 16, 32
    function automatic logic [5:0] mbiram_colw(input logic [1:0] code);
        return 6'h04 << code;
    endfunction

    // Data array address bits; 00 and 01 both mean the smallest cache
    function automatic logic [3:0] mbiram_daddr(input logic [1:0] code);
        return (code == 2'h3) ? 4'hB : (code == 2'h2) ? 4'hA : 4'h9;
    endfunction

    // Bits compared on one CPU lane for the arrays selected
    function automatic logic [DATA_W-1:0] mbiram_mask(input logic [NSEL-1:0] sel,
                                                      input logic [1:0] csize);
        logic [DATA_W-1:0] m;
        logic [21:0] dt;
        m = 64'h0;
        dt = (csize == 2'h3) ? 22'h3FFFFC : (csize == 2'h2) ? 22'h3FFFFE : 22'h3FFFFF;
        if (|sel[15:12] || |sel[8:5]) m = 64'hFFFFFFFFFFFFFFFF;
        if (|sel[11:10]) m = m | {10'h000, dt, 10'h000, dt};
        if (sel[9]) m = m | 64'h0000000000FFFFFF;
        if (|sel[4:3]) m = m | 64'h001FFFFF001FFFFF;
        if (sel[2]) m = m | 64'h7FFFFFFFFFFFFFFF;
        if (|sel[1:0]) m = m | 64'h0FFFFFFFFFFFFFFF;
        if (|sel[17:16]) m = m | 64'h00000FFFFFFFFFFF;
        return m;
    endfunction

endpackage

// file: verif/mbiram_tester.sv
// Behavioural test equipment: serial instruction load, run control, log read-out.
// Assumes it shares aclk with the block and changes its outputs just after rising edges.
`timescale 1ns/1ps
`default_nettype none

module mbiram_tester
    import mbiram_pkg::*;
(
    input wire logic aclk,
    input wire logic [NCPU-1:0] serial_result,
    output logic serial_instr_in,
    output logic instr_shift_en,
    output logic log_shift_en,
    output logic test_run_en
);
    initial begin
        serial_instr_in = 1'h0;
        instr_shift_en = 1'h0;
        log_shift_en = 1'h0;
        test_run_en = 1'h0;
    end

    // ==========================================================
    // Instruction load, bit 0 first
    task automatic load(input logic [INSTR_W-1:0] instr);
        int i;
        @(posedge aclk);
        test_run_en <= 1'h0;
        for (i = 0; i < INSTR_W; i++) begin
            serial_instr_in <= instr[i];
            instr_shift_en <= 1'h1;
            @(posedge aclk);
        end
        instr_shift_en <= 1'h0;
        // Line is not driven between loads: show the inverse, never a stale bit
        serial_instr_in <= ~instr[INSTR_W-1];
    endtask

    task automatic set_run(input logic on);
        @(posedge aclk);
        test_run_en <= on;
    endtask

    // ==========================================================
    // Log read-out on all lanes at once
    task automatic read_logs(output logic [NCPU-1:0][LOG_W-1:0] logs);
        int k;
        int c;
        logs = '0;
        @(posedge aclk);
        log_shift_en <= 1'h1;
        @(posedge aclk);
        for (k = 0; k < LOG_W; k++) begin
            @(posedge aclk);
            for (c = 0; c < NCPU; c++) begin
                logs[c][k] = serial_result[c];
            end
        end
        log_shift_en <= 1'h0;
    endtask
endmodule // mbiram_tester

`default_nettype wire

// file: verif/test_memory_bist_instruction_and_ram_map.sv
// Self-checking bench of the self-test instruction block and its register bus.
// Assumes the tester model in mbiram_tester.sv and the package constants.
`timescale 1ns/1ps
`default_nettype none

module test_memory_bist_instruction_and_ram_map
    import mbiram_pkg::*;
;
    typedef struct packed {
        logic [INSTR_W-1:0] instr;
        logic [3:0] seed;
        logic [5:0] colw;
        logic [3:0] dbits;
    } mbiram_row_s;

    logic aclk, aresetn, read_check;
    logic serial_instr_in, instr_shift_en, log_shift_en, test_run_en;
    logic [ADDR_W-1:0] test_address;
    logic [DATA_W-1:0] test_write_data;
    logic [NCPU*DATA_W-1:0] test_read_data;
    logic [NSEL-1:0] ram_select;
    logic [5:0] pattern_sel, ctrl_options, column_width;
    logic [2:0] write_latency, read_latency;
    logic [3:0] max_x_addr, max_y_addr, data_seed, data_addr_bits, tag_addr_bits;
    logic [NCPU-1:0] serial_result;
    logic fail_detect, ctrl_stall;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [NCPU-1:0][LOG_W-1:0] logs;
    logic [INSTR_W-1:0] inst;
    mbiram_row_s rows [4];
    int failures, cmp_count, stall_cnt;

    mbiram_core u_mbiram_core (.aclk(aclk), .aresetn(aresetn),
        .serial_instr_in(serial_instr_in), .instr_shift_en(instr_shift_en),
        .log_shift_en(log_shift_en), .test_run_en(test_run_en), .read_check(read_check),
        .test_address(test_address), .test_write_data(test_write_data),
        .test_read_data(test_read_data), .ram_select(ram_select), .pattern_sel(pattern_sel),
        .ctrl_options(ctrl_options), .write_latency(write_latency),
        .read_latency(read_latency), .max_x_addr(max_x_addr), .max_y_addr(max_y_addr),
        .data_seed(data_seed), .column_width(column_width), .data_addr_bits(data_addr_bits),
        .tag_addr_bits(tag_addr_bits), .serial_result(serial_result),
        .fail_detect(fail_detect), .ctrl_stall(ctrl_stall), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    mbiram_tester u_mbiram_tester (.aclk(aclk), .serial_result(serial_result),
        .serial_instr_in(serial_instr_in), .instr_shift_en(instr_shift_en),
        .log_shift_en(log_shift_en), .test_run_en(test_run_en));

    always #25 aclk = ~aclk;

    always @(posedge aclk) begin
        if (ctrl_stall === 1'h1) stall_cnt <= stall_cnt + 1;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Register bus master
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) begin
            failures++;
            finish_test();
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) begin
            failures++;
            finish_test();
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // One compare cycle; flip marks the read bits that differ from expected data
    task automatic compare(input logic [NCPU*DATA_W-1:0] flip);
        @(posedge aclk);
        read_check <= 1'h1;
        test_address <= 11'h5A3;
        test_write_data <= 64'hA5A5A5A5A5A5A5A5;
        test_read_data <= {NCPU{64'hA5A5A5A5A5A5A5A5}} ^ flip;
        @(posedge aclk);
        read_check <= 1'h0;
        repeat (2) @(posedge aclk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        read_check = 1'h0;
        test_address = '0;
        test_write_data = '0;
        test_read_data = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        failures = 0;
        cmp_count = 0;
        stall_cnt = 0;
        rows[0] = '{56'h123456789ABCD0, 4'h2, 6'h04, 4'h9};
        rows[1] = '{56'hABCDEF01234565, 4'h4, 6'h08, 4'h9};
        rows[2] = '{56'h0F0F0F0F0F0F0A, 4'hC, 6'h10, 4'hA};
        rows[3] = '{56'hFC000000F0000F, 4'h5, 6'h20, 4'hB};
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(OFS_CTRL, d, r);
        check(d[1:0], 2'h1);
        for (int i = 0; i < 4; i++) begin
            u_mbiram_tester.load(rows[i].instr);
            repeat (3) @(posedge aclk);
            check(pattern_sel, rows[i].instr[55:50]);
            check(ctrl_options, rows[i].instr[49:44]);
            check({write_latency, read_latency}, rows[i].instr[43:38]);
            check({max_x_addr, max_y_addr}, rows[i].instr[33:26]);
            check(data_seed, rows[i].seed);
            check(column_width, rows[i].colw);
            check(data_addr_bits, rows[i].dbits);
            check(tag_addr_bits, rows[i].dbits - 4'h2);
            axi_read(OFS_INSTR_LO, d, r);
            check(d, rows[i].instr[31:0]);
            axi_read(OFS_INSTR_HI, d, r);
            check(d[23:0], rows[i].instr[55:32]);
        end
        axi_read(OFS_CFG, d, r);
        check(d[15:0], 16'h9B20);
        // Data way 0 on CPU1 only; CPU0 also miscompares but is not enabled
        inst = (56'h1 << 50) | (56'h1 << 34) | (56'hB << 22) | (56'h1 << 16);
        u_mbiram_tester.load(inst);
        u_mbiram_tester.set_run(1'h1);
        repeat (2) @(posedge aclk);
        check(ram_select, inst[21:4]);
        compare({128'h0, 64'h81, 64'h1});
        check(fail_detect, 1'h1);
        axi_read(OFS_STATUS, d, r);
        check(d[5:0], 6'h12);
        u_mbiram_tester.read_logs(logs);
        repeat (3) @(posedge aclk);
        check(logs[1], {11'h5A3, 64'h81, 4'hB});
        check(logs[0] | logs[2] | logs[3], 79'h0);
        check(stall_cnt, LOG_W + 1);
        axi_write(OFS_CTRL, 32'h3, r);
        repeat (2) @(posedge aclk);
        check(fail_detect, 1'h0);
        // Tag ways at the largest cache: the two low tag bits are not compared
        inst = (56'h1 << 33) | (56'h1 << 14) | 56'h3;
        u_mbiram_tester.load(inst);
        u_mbiram_tester.set_run(1'h1);
        repeat (2) @(posedge aclk);
        compare({192'h0, 64'h3});
        check(fail_detect, 1'h0);
        compare({192'h0, 64'h4});
        check(fail_detect, 1'h1);
        axi_read(8'h40, d, r);
        check(r, RESP_SLVERR);
        axi_write(8'h44, 32'h1, r);
        check(r, RESP_SLVERR);
        // Branch target (j=0) and instruction tag (j=1): padding bit, then a data bit
        for (int j = 0; j < 2; j++) begin
            axi_write(OFS_CTRL, 32'h3, r);
            u_mbiram_tester.load((56'h1 << 33) | (56'h1 << (6 + j)));
            u_mbiram_tester.set_run(1'h1);
            compare({192'h0, j ? 64'h0000000000200000 : 64'h8000000000000000});
            check(fail_detect, 1'h0);
            compare({192'h0, j ? 64'h0000000000100000 : 64'h4000000000000000});
            check(fail_detect, 1'h1);
        end
        // Second reset after the run is stopped clears the fail flag and the instruction
        u_mbiram_tester.set_run(1'h0);
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        check({fail_detect, ctrl_stall, ram_select}, 20'h0);
        axi_read(OFS_INSTR_LO, d, r);
        check(d, 32'h0);
        finish_test();
    end
endmodule // test_memory_bist_instruction_and_ram_map

`default_nettype wire
